// >>> rtl/flash_ident_defines.vh
// Notes on behaviour
// - host selects, shifts command; device returns id
// - busy erase/program: command ignored undecoded
// - select release stops output, standby
// - standard id read single line only
// - multi-line id read: quad in, dual out
// - order: maker, type, capacity, unique id
// - unique id: length 10h, two codes, 14 data
// - unique id only on standard id read
// - extended code byte field layout
// - parameter read: cmd, 3 address, 8 dummies
// - parameter address wraps at 2048 bytes
// - parameter read always continuous burst
// - signature bytes 53h 46h 44h 50h
// - revisions 00h 01h, count 00h, FFh
// - first header bytes 08h to 0Fh
`ifndef FLASH_IDENT_DEFINES_VH
`define FLASH_IDENT_DEFINES_VH
`define CMD_IDENT_READ        8'h9f
`define CMD_MULTI_IDENT_READ  8'haf
`define CMD_PARAM_READ        8'h5a
`define PROTO_EXTENDED        2'h0
`define PROTO_DUAL            2'h1
`define PROTO_QUAD            2'h2
`define UID_LENGTH            8'h10
`define IDENT_LEN_FULL        5'h14
`define IDENT_LEN_SHORT       5'h03
`define PARAM_ADDR_BYTES      2'h3
`define PARAM_DUMMY_CLOCKS    4'h8
`define PARAM_ADDR_WIDTH      11
`define EXT_BIT_PROT_SCHEME   5
`define EXT_BIT_VOLATILE_CFG  4
`define EXT_BIT_RESET_PIN     3
`define EXT_BIT_ADDRESSING    2
`define ARCH_UNIFORM          2'h0
`define MAKER_CODE_DEFAULT    8'h5c
`define MEM_TYPE_DEFAULT      8'h3a
`define MEM_CAP_DEFAULT       8'h4e
`endif

// >>> rtl/pin_sync.v
`timescale 1ns/100ps
module pin_sync (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire [6:0] async_in,
  output reg  [6:0] sync_out
);
  reg [6:0] meta_reg;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      meta_reg <= 7'h40;
      sync_out <= 7'h40;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pin_sync

// >>> rtl/param_table_rom.v
`timescale 1ns/100ps
`include "flash_ident_defines.vh"
module param_table_rom (
  input  wire [10:0] addr,
  input  wire [7:0]  body_byte,
  output reg  [7:0]  data
);
  always @* begin
    case (addr)
      11'h000: data = 8'h53;
      11'h001: data = 8'h46;
      11'h002: data = 8'h44;
      11'h003: data = 8'h50;
      11'h004: data = 8'h00;
      11'h005: data = 8'h01;
      11'h006: data = 8'h00;
      11'h007: data = 8'hff;
      11'h008: data = 8'h00;
      11'h009: data = 8'h00;
      11'h00a: data = 8'h01;
      11'h00b: data = 8'h09;
      11'h00c: data = 8'h30;
      11'h00d: data = 8'h00;
      11'h00e: data = 8'h00;
      11'h00f: data = 8'hff;
      default: begin
        if (addr < 11'h020)
          data = 8'hff;
        else
          data = body_byte;
      end
    endcase
  end
endmodule // param_table_rom

// >>> rtl/flash_ident_readout.v
`timescale 1ns/100ps
`include "flash_ident_defines.vh"
module flash_ident_readout (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        chip_sel_n,
  input  wire        serial_clk,
  input  wire [3:0]  serial_io_lines_in,
  output reg  [3:0]  serial_io_lines_out,
  output reg  [3:0]  serial_io_lines_oe,
  input  wire [1:0]  protocol_sel,
  input  wire        array_busy,
  input  wire        alt_protect_scheme,
  input  wire        volatile_cfg_not_required,
  input  wire        reset_pin_function,
  input  wire [7:0]  ext_code_second,
  input  wire [111:0] factory_data,
  input  wire [7:0]  param_body_byte,
  output reg  [10:0] param_addr,
  output reg         id_active,
  output reg         param_active,
  output reg         cmd_ignored
);
  parameter [7:0] MAKER_CODE = `MAKER_CODE_DEFAULT; // arbitrary value
  parameter [7:0] MEM_TYPE   = `MEM_TYPE_DEFAULT;   // arbitrary value
  parameter [7:0] MEM_CAP    = `MEM_CAP_DEFAULT;    // arbitrary value

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CMD   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_DUMMY = 3'h3;
  localparam [2:0] ST_OUT   = 3'h4;
  localparam [2:0] ST_SKIP  = 3'h5;

  wire [6:0] sync_w;
  wire       sel_n_s;
  wire       sclk_s;
  wire [3:0] io_s;
  wire [7:0] rom_byte;

  reg  [2:0]  state_reg;
  reg         sclk_d_reg;
  reg  [7:0]  shift_reg;
  reg  [4:0]  bit_cnt_reg;
  reg  [4:0]  byte_idx_reg;
  reg  [1:0]  addr_cnt_reg;
  reg  [23:0] addr_acc_reg;
  reg  [3:0]  dummy_cnt_reg;
  reg  [7:0]  out_byte_reg;
  reg         multi_reg;
  reg         param_mode_reg;
  reg         out_started_reg;

  wire rise = sclk_s & ~sclk_d_reg;
  wire fall = ~sclk_s & sclk_d_reg;
  wire quad_cmd = (protocol_sel != `PROTO_EXTENDED);

  assign sel_n_s = sync_w[6];
  assign sclk_s  = sync_w[5];
  assign io_s    = sync_w[3:0];

  pin_sync u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in ({chip_sel_n, serial_clk, 1'b0, serial_io_lines_in}),
    .sync_out (sync_w)
  );

  param_table_rom u_rom (
    .addr      (param_addr),
    .body_byte (param_body_byte),
    .data      (rom_byte)
  );

  function [7:0] ext_code_first;
    input alt;
    input vcfg;
    input rst_pin;
    begin
      ext_code_first = {2'b00, alt, vcfg, rst_pin, 1'b0, `ARCH_UNIFORM};
    end
  endfunction

  function [7:0] ident_byte;
    input [4:0]   idx;
    input [7:0]   ext0;
    input [7:0]   ext1;
    input [111:0] fdata;
    begin
      case (idx)
        5'h00: ident_byte = MAKER_CODE;
        5'h01: ident_byte = MEM_TYPE;
        5'h02: ident_byte = MEM_CAP;
        5'h03: ident_byte = `UID_LENGTH;
        5'h04: ident_byte = ext0;
        5'h05: ident_byte = ext1;
        default: begin
          if (idx < `IDENT_LEN_FULL)
            ident_byte = fdata[(idx - 5'h06) * 8 +: 8];
          else
            ident_byte = 8'h00;
        end
      endcase
    end
  endfunction

  wire [7:0] ext0_w = ext_code_first(alt_protect_scheme, volatile_cfg_not_required,
                                     reset_pin_function);

  // data beats per byte: single line 8, dual line 4
  wire [4:0] out_bits = multi_reg ? 5'h04 : 5'h08;
  // last byte index before the id stream wraps
  wire [4:0] ident_last = (multi_reg ? `IDENT_LEN_SHORT : `IDENT_LEN_FULL) - 5'h01;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg           <= ST_IDLE;
      sclk_d_reg          <= 1'b0;
      shift_reg           <= 8'h00;
      bit_cnt_reg         <= 5'h00;
      byte_idx_reg        <= 5'h00;
      addr_cnt_reg        <= 2'h0;
      addr_acc_reg        <= 24'h000000;
      dummy_cnt_reg       <= 4'h0;
      out_byte_reg        <= 8'h00;
      multi_reg           <= 1'b0;
      param_mode_reg      <= 1'b0;
      out_started_reg     <= 1'b0;
      param_addr          <= 11'h000;
      serial_io_lines_out <= 4'h0;
      serial_io_lines_oe  <= 4'h0;
      id_active           <= 1'b0;
      param_active        <= 1'b0;
      cmd_ignored         <= 1'b0;
    end else begin
      sclk_d_reg  <= sclk_s;
      cmd_ignored <= 1'b0;
      if (sel_n_s) begin
        state_reg          <= ST_IDLE;
        serial_io_lines_oe <= 4'h0;
        id_active          <= 1'b0;
        param_active       <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            state_reg       <= ST_CMD;
            bit_cnt_reg     <= 5'h00;
            shift_reg       <= 8'h00;
            out_started_reg <= 1'b0;
          end
          ST_CMD: begin
            if (rise) begin
              if (quad_cmd) begin
                shift_reg   <= {shift_reg[3:0], io_s};
                bit_cnt_reg <= bit_cnt_reg + 5'h04;
              end else begin
                shift_reg   <= {shift_reg[6:0], io_s[0]};
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
              end
            end else if (bit_cnt_reg == 5'h08) begin
              bit_cnt_reg  <= 5'h00;
              byte_idx_reg <= 5'h00;
              if (array_busy) begin
                state_reg   <= ST_SKIP;
                cmd_ignored <= 1'b1;
              end else if (shift_reg == `CMD_IDENT_READ && !quad_cmd) begin
                multi_reg <= 1'b0;
                state_reg <= ST_OUT;
                id_active <= 1'b1;
                param_mode_reg <= 1'b0;
              // multi id in dual or quad
              end else if (shift_reg == `CMD_MULTI_IDENT_READ && quad_cmd) begin
                multi_reg <= 1'b1;
                state_reg <= ST_OUT;
                id_active <= 1'b1;
                param_mode_reg <= 1'b0;
              end else if (shift_reg == `CMD_PARAM_READ && !quad_cmd) begin
                multi_reg      <= 1'b0;
                param_mode_reg <= 1'b1;
                addr_cnt_reg   <= 2'h0;
                state_reg      <= ST_ADDR;
              end else begin
                state_reg <= ST_SKIP;
              end
            end
          end
          ST_ADDR: begin
            if (rise) begin
              addr_acc_reg <= {addr_acc_reg[22:0], io_s[0]};
              bit_cnt_reg  <= bit_cnt_reg + 5'h01;
            end else if (bit_cnt_reg == 5'h08) begin
              bit_cnt_reg  <= 5'h00;
              if (addr_cnt_reg == `PARAM_ADDR_BYTES - 2'h1) begin
                state_reg     <= ST_DUMMY;
                dummy_cnt_reg <= 4'h0;
              end else begin
                addr_cnt_reg <= addr_cnt_reg + 2'h1;
              end
            end
          end
          ST_DUMMY: begin
            param_addr <= addr_acc_reg[10:0];
            if (dummy_cnt_reg == `PARAM_DUMMY_CLOCKS) begin
              state_reg    <= ST_OUT;
              param_active <= 1'b1;
            end else if (rise) begin
              dummy_cnt_reg <= dummy_cnt_reg + 4'h1;
            end
          end
          ST_OUT: begin
            // first fall after command or dummies loads first byte
            if (fall) begin
              if (!out_started_reg || bit_cnt_reg == out_bits - 5'h01) begin
                out_started_reg <= 1'b1;
                bit_cnt_reg     <= 5'h00;
                if (param_mode_reg) begin
                  out_byte_reg <= rom_byte;
                  param_addr   <= param_addr + 11'h001;
                end else begin
                  out_byte_reg <= ident_byte(byte_idx_reg, ext0_w, ext_code_second,
                                             factory_data);
                  if (byte_idx_reg == ident_last)
                    byte_idx_reg <= 5'h00;
                  else
                    byte_idx_reg <= byte_idx_reg + 5'h01;
                end
              end else begin
                out_byte_reg <= multi_reg ? {out_byte_reg[5:0], 2'b00}
                                          : {out_byte_reg[6:0], 1'b0};
                bit_cnt_reg  <= bit_cnt_reg + 5'h01;
              end
            end
            if (multi_reg) begin
              serial_io_lines_oe  <= 4'h3;
              serial_io_lines_out <= {2'b00, out_byte_reg[7:6]};
            end else begin
              serial_io_lines_oe  <= 4'h1;
              serial_io_lines_out <= {3'b000, out_byte_reg[7]};
            end
          end
          default: begin
            serial_io_lines_oe <= 4'h0;
          end
        endcase
      end
    end
  end
endmodule // flash_ident_readout

// >>> sim/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
  input  wire       clk_sys,
  output reg        chip_sel_n,
  output reg        serial_clk,
  output wire [3:0] serial_io_lines_in,
  input  wire [3:0] serial_io_lines_out,
  input  wire [3:0] serial_io_lines_oe
);
  reg [3:0] drv;
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    drv        = 4'h0;
  end
  assign serial_io_lines_in = (serial_io_lines_oe & serial_io_lines_out) | (~serial_io_lines_oe & drv);
  // one serial clock, sample at rise
  task xfer(input [3:0] d, output [3:0] q);
    begin
      @(posedge clk_sys) drv <= d;
      repeat (6) @(posedge clk_sys);
      q = serial_io_lines_in;
      serial_clk <= 1'b1;
      repeat (6) @(posedge clk_sys);
      serial_clk <= 1'b0;
    end
  endtask
  task send(input [7:0] b, input quad);
    integer i;
    reg [3:0] q;
    begin
      if (quad) begin
        xfer(b[7:4], q);
        xfer(b[3:0], q);
      end else begin
        for (i = 7; i >= 0; i = i - 1) xfer({3'b101, b[i]}, q);
      end
    end
  endtask
  task get(input dual, output [7:0] b);
    integer i;
    reg [3:0] q;
    begin
      b = 8'h00;
      for (i = 0; i < (dual ? 4 : 8); i = i + 1) begin
        xfer(i[0] ? 4'ha : 4'h5, q);
        b = dual ? {b[5:0], q[1:0]} : {b[6:0], q[0]};
      end
    end
  endtask
  task frame_start;
    begin
      @(posedge clk_sys) chip_sel_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask
  task frame_end;
    begin
      @(posedge clk_sys) chip_sel_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
    end
  endtask
endmodule // spi_host_model

// >>> sim/flash_ident_monitor.sv
`timescale 1ns/100ps
module flash_ident_monitor (
  input wire       clk_sys,
  input wire       rstn,
  input wire       chip_sel_n,
  input wire [1:0] protocol_sel,
  input wire [3:0] serial_io_lines_oe,
  input wire       id_active,
  input wire       param_active,
  input wire       cmd_ignored
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_release_quiet: assert property (chip_sel_n [*6] |-> serial_io_lines_oe == 4'h0)
    else $error("output enabled after deselect");
  chk_release_idle: assert property (chip_sel_n [*6] |-> !id_active && !param_active)
    else $error("read active after deselect");
  chk_busy_mute: assert property (cmd_ignored |-> (serial_io_lines_oe == 4'h0 && !id_active) [*8])
    else $error("output after ignored command");
  chk_ignore_pulse: assert property (cmd_ignored |=> !cmd_ignored)
    else $error("ignore flag longer than one cycle");
  chk_single_line: assert property (id_active && protocol_sel == 2'h0 |-> serial_io_lines_oe[3:1] == 3'h0)
    else $error("standard id read drives extra lines");
  chk_dual_out: assert property (id_active && protocol_sel != 2'h0 |-> serial_io_lines_oe[3:2] == 2'h0)
    else $error("multi-line id read drives upper lines");
  chk_one_command: assert property (id_active |-> !param_active)
    else $error("two reads active at once");
  chk_oe_cause: assert property (serial_io_lines_oe != 4'h0 |->
    id_active || param_active || $past(id_active) || $past(param_active))
    else $error("output enabled with no read active");
endmodule // flash_ident_monitor
bind flash_ident_readout flash_ident_monitor mon_u (.clk_sys(clk_sys), .rstn(rstn),
  .chip_sel_n(chip_sel_n), .protocol_sel(protocol_sel), .serial_io_lines_oe(serial_io_lines_oe),
  .id_active(id_active), .param_active(param_active), .cmd_ignored(cmd_ignored));

// >>> sim/serial_flash_ident_readout_bench.sv
`timescale 1ns/100ps
`include "flash_ident_defines.vh"
module serial_flash_ident_readout_bench;
  localparam [111:0] FDATA = 112'h1e1d1c1b1a191817161514131211;
  localparam [255:0] HDR = 256'h53464450_000100ff_00000109_300000ff_ffffffff_ffffffff_ffffffff_ffffffff;
  reg         clk_sys = 1'b0;
  reg         rstn = 1'b0;
  reg  [1:0]  protocol_sel = 2'h0;
  reg         array_busy = 1'b0;
  integer     ign_cnt = 0;
  wire        chip_sel_n, serial_clk, id_active, param_active, cmd_ignored;
  wire [3:0]  lines_in, lines_out, lines_oe;
  wire [10:0] param_addr;
  integer     num_errors = 0;
  integer     checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (cmd_ignored) ign_cnt <= ign_cnt + 1;
  flash_ident_readout dut_u (.clk_sys(clk_sys), .rstn(rstn), .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk), .serial_io_lines_in(lines_in), .serial_io_lines_out(lines_out),
    .serial_io_lines_oe(lines_oe), .protocol_sel(protocol_sel), .array_busy(array_busy),
    .alt_protect_scheme(1'b1), .volatile_cfg_not_required(1'b0), .reset_pin_function(1'b0),
    .ext_code_second(8'h42), .factory_data(FDATA), .param_body_byte(8'h6c),
    .param_addr(param_addr), .id_active(id_active), .param_active(param_active),
    .cmd_ignored(cmd_ignored));
  spi_host_model host_u (.clk_sys(clk_sys), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
    .serial_io_lines_in(lines_in), .serial_io_lines_out(lines_out),
    .serial_io_lines_oe(lines_oe));
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  function [7:0] id_exp(input integer i);
    case (i)
      0: id_exp = `MAKER_CODE_DEFAULT;
      1: id_exp = `MEM_TYPE_DEFAULT;
      2: id_exp = `MEM_CAP_DEFAULT;
      3: id_exp = 8'h10;
      4: id_exp = {2'b00, 1'b1, 5'h00};
      5: id_exp = 8'h42;
      default: id_exp = FDATA[8*(i-6) +: 8];
    endcase
  endfunction
  task t_ident;
    reg [7:0] b;
    integer i;
    begin
      protocol_sel <= `PROTO_EXTENDED;
      host_u.frame_start;
      host_u.send(`CMD_IDENT_READ, 1'b0);
      for (i = 0; i < 21; i = i + 1) begin
        host_u.get(1'b0, b);
        cmp(i == 4 ? {2'b00, b[5:0]} : b, id_exp(i % 20));
      end
      cmp({7'h00, id_active}, 8'h01);
      host_u.frame_end;
      cmp({4'h0, lines_oe}, 8'h00);
    end
  endtask
  task t_multi;
    reg [7:0] b;
    integer i, p;
    begin
      for (p = 1; p < 3; p = p + 1) begin
        protocol_sel <= p[1:0];
        host_u.frame_start;
        host_u.send(`CMD_MULTI_IDENT_READ, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
          host_u.get(1'b1, b);
          cmp(b, id_exp(i % 3));
        end
        host_u.frame_end;
      end
    end
  endtask
  task t_busy;
    reg [7:0] b;
    integer ign_base;
    begin
      protocol_sel <= `PROTO_EXTENDED;
      array_busy <= 1'b1;
      ign_base = ign_cnt;
      host_u.frame_start;
      host_u.send(`CMD_IDENT_READ, 1'b0);
      host_u.get(1'b0, b);
      cmp(8'(ign_cnt - ign_base), 8'h01);
      cmp({3'h0, id_active, lines_oe}, 8'h00);
      host_u.frame_end;
      array_busy <= 1'b0;
    end
  endtask
  task t_param(input [10:0] a, input integer n);
    reg [7:0] b;
    reg [3:0] q;
    integer i, k;
    begin
      host_u.frame_start;
      host_u.send(`CMD_PARAM_READ, 1'b0);
      host_u.send(8'h00, 1'b0);
      host_u.send({5'h00, a[10:8]}, 1'b0);
      host_u.send(a[7:0], 1'b0);
      for (i = 0; i < 8; i = i + 1) host_u.xfer(4'h0, q);
      for (i = 0; i < n; i = i + 1) begin
        host_u.get(1'b0, b);
        k = (a + i) % 2048;
        cmp(b, k < 32 ? HDR[255-8*k -: 8] : 8'h6c);
      end
      host_u.frame_end;
    end
  endtask
  task test_done;
    begin
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_ident;
    t_multi;
    t_busy;
    t_param(11'h000, 32);
    t_param(11'h7fe, 4);
    test_done;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    test_done;
  end
endmodule // serial_flash_ident_readout_bench
